//--- burst_write_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and carriers for the burst byte write port.
// Assumes: One 200 MHz core clock; both data phases of a cycle arrive together.
// Notes:   Widths are sized for the widest (36-bit) organisation.
//////////////////////////////////////////////////////////////////////////////
package burst_write_pkg;

    // Core clock period in ns (200 MHz)
    localparam int CLK_PERIOD_NS = 5;
    // Stages of the pin synchroniser
    localparam int SYNC_STAGES = 2;
    // Width of one byte lane, including its parity-style ninth bit
    localparam int LANE_W = 9;
    // Lanes of the widest organisation
    localparam int MAX_LANES = 4;
    localparam int MAX_DATA_W = LANE_W * MAX_LANES;
    // Organisations that the logic can serve
    localparam int ORG_NARROW = 18;
    localparam int ORG_WIDE = 36;
    // Word address width of the flop array
    localparam int ADDR_W = 6;
    // Words per burst and words per core cycle
    localparam int BURST_LEN = 4;
    localparam int BEATS_PER_CYCLE = 2;
    // Address step between the two beat pairs of a burst
    localparam logic [ADDR_W-1:0] PAIR_STEP = 6'h02;
    // Step between the two beats of one pair
    localparam logic [ADDR_W-1:0] BEAT_STEP = 6'h01;
    // Reset values
    localparam logic [MAX_DATA_W-1:0] WORD_RESET = 36'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [MAX_DATA_W-1:0] word_t;
    typedef logic [MAX_LANES-1:0] lanes_t;

    // Pin group as seen after the pads; both data phases side by side
    typedef struct packed {
        logic write_port_select_n;
        logic read_port_select_n;
        addr_t addr;
        word_t data_pos;
        word_t data_neg;
        lanes_t lane_write_select_pos_n;
        lanes_t lane_write_select_neg_n;
    } pin_s;

    // One core cycle of write data: two beats with active-high lane enables
    typedef struct packed {
        addr_t addr;
        word_t data0;
        word_t data1;
        lanes_t en0;
        lanes_t en1;
    } beat_pair_s;

    // Last operation initiated, used for arbitration and spacing
    typedef enum logic [1:0] {
        OP_NONE,
        OP_READ,
        OP_WRITE
    } last_op_e;

    // Data phase of a write burst
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_FIRST_PAIR,
        WR_SECOND_PAIR
    } wr_phase_e;

endpackage : burst_write_pkg

//--- pair_buffer.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Small valid/ready buffer for captured beat pairs.
// Assumes: Single clock; asynchronous active-low reset.
// Notes:   Full and empty are exact; a stalled drain really fills it.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps

module pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_in,                 // Core clock
    input wire logic rst_n_in,               // Async reset, active low
    input wire logic in_valid_in,            // Source offers a word
    output logic in_ready_out,               // Room for a word
    input wire logic [WIDTH-1:0] in_data_in, // Word from source
    output logic out_valid_out,              // Word available
    input wire logic out_ready_in,           // Drain takes the word
    output logic [WIDTH-1:0] out_data_out,   // Oldest word
    output logic [$clog2(DEPTH+1)-1:0] level_out // Words held
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH+1);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("pair_buffer needs DEPTH >= 2 and WIDTH >= 1");
        end
    end

    logic [WIDTH-1:0] slot_r [DEPTH];
    logic [WIDTH-1:0] slot_nxt [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CNT_W-1:0] count_r, count_nxt;
    logic push, pop;

    assign in_ready_out = (count_r != CNT_W'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out = slot_r[rd_ptr_r];
    assign level_out = count_r;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Pointer, count and slot updates; pointers wrap at DEPTH
    always_comb begin
        slot_nxt = slot_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        if (push) begin
            slot_nxt[wr_ptr_r] = in_data_in;
            wr_ptr_nxt = (wr_ptr_r == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
        end
        count_nxt = count_r + CNT_W'(push) - CNT_W'(pop);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                slot_r[i] <= '0;
            end
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            slot_r <= slot_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

endmodule : pair_buffer

//--- burst_byte_write_port.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Write-port data path of a four-word-burst memory with lane masks.
// Assumes: Pads deliver both data phases of a cycle on separate buses.
// Notes:   Pins are synchronised by two flops; the array is made of flops.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps

// Notes on behaviour
// - Narrow organisation, both lane selects low: all 18 bits of the beat written.
// - Narrow, only lane 0 selected: bits 8..0 written, bits 17..9 kept.
// - Narrow, only lane 1 selected: bits 17..9 written, bits 8..0 kept.
// - Narrow, both selects high: the stored word is not touched for that beat.
// - Wide organisation, all four selects low: the whole 36-bit beat is written.
// - Wide, only lane 0 selected: bits 8..0 written, the rest kept.
// - Wide, only lane 1 selected: bits 17..9 written, the rest kept.
// - Wide, only lane 2 selected: bits 26..18 written, the rest kept.
// - Wide, only lane 3 selected: bits 35..27 written, the rest kept.
// - Wide, all selects high: the stored word is not touched for that beat.
// - Each beat is taken with its own lane selects on both clock phases.
// - Lane selects may differ per beat; each beat uses its own.
// - After reset the port is deselected and drives nothing.
// - Beats of a burst at address A go to A, A+1, A+2, A+3.
// - A select that started an operation last cycle is don't-care this cycle.
// - Write starts at t; beats one, two at t+1, beats three, four at t+2.
// - Port selects are sampled on the positive phase only.
module burst_byte_write_port #(
    parameter int ORG_W = burst_write_pkg::ORG_WIDE,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_in,                     // Core clock, 200 MHz
    input wire logic rst_n_in,                   // Async reset, active low
    input wire logic write_port_select_n_in,     // Write port select, low starts
    input wire logic read_port_select_n_in,      // Read port select, low starts
    input wire burst_write_pkg::addr_t addr_in,  // Burst start address
    input wire burst_write_pkg::word_t data_pos_in, // Beat on the positive phase
    input wire burst_write_pkg::word_t data_neg_in, // Beat on the negative phase
    input wire burst_write_pkg::lanes_t lane_write_select_pos_n_in, // Lane selects, pos beat
    input wire burst_write_pkg::lanes_t lane_write_select_neg_n_in, // Lane selects, neg beat
    input wire logic array_hold_in,              // Array busy, stalls commit
    input wire burst_write_pkg::addr_t peek_addr_in, // Array inspection address
    output burst_write_pkg::word_t peek_data_out,   // Stored word at peek address
    output logic write_taken_out,                // Pulse: write initiated
    output logic read_taken_out,                 // Pulse: read initiated
    output logic start_refused_out,              // Pulse: a start was ignored
    output logic overrun_out,                    // Pulse: beat pair lost
    output logic port_active_out                 // Port selected or draining
);

    localparam int LANES = ORG_W / burst_write_pkg::LANE_W;
    localparam int DEPTH = 2 ** burst_write_pkg::ADDR_W;
    localparam int PAIR_W = $bits(burst_write_pkg::beat_pair_s);
    localparam int LVL_W = $clog2(BUF_DEPTH+1);

    initial begin
        if (!(ORG_W == burst_write_pkg::ORG_NARROW || ORG_W == burst_write_pkg::ORG_WIDE)) begin
            $error("ORG_W must be 18 or 36");
        end
        if (BUF_DEPTH < 2) begin
            $error("BUF_DEPTH must be at least 2");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: first stage feeds only the second
    burst_write_pkg::pin_s pin_raw, pin_meta_r, pin_r;
    burst_write_pkg::pin_s pin_meta_nxt, pin_nxt;

    assign pin_raw = '{write_port_select_n: write_port_select_n_in,
                       read_port_select_n: read_port_select_n_in,
                       addr: addr_in, data_pos: data_pos_in, data_neg: data_neg_in,
                       lane_write_select_pos_n: lane_write_select_pos_n_in,
                       lane_write_select_neg_n: lane_write_select_neg_n_in};

    always_comb begin
        pin_meta_nxt = pin_raw;
        pin_nxt = pin_meta_r;
    end

    // Selects idle high so no start is seen while the chain fills
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_r <= '{write_port_select_n: 1'b1, read_port_select_n: 1'b1,
                            lane_write_select_pos_n: '1, lane_write_select_neg_n: '1, default: '0};
            pin_r <= '{write_port_select_n: 1'b1, read_port_select_n: 1'b1,
                       lane_write_select_pos_n: '1, lane_write_select_neg_n: '1, default: '0};
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_r <= pin_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lanes that exist in this organisation; absent lanes are never written
    burst_write_pkg::lanes_t lane_exists;
    generate
        for (genvar l = 0; l < burst_write_pkg::MAX_LANES; l++) begin : g_lane
            assign lane_exists[l] = (l < LANES);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Start arbitration and burst sequencing
    burst_write_pkg::last_op_e last_op_r, last_op_nxt;
    burst_write_pkg::wr_phase_e phase_r, phase_nxt;
    burst_write_pkg::addr_t base_r, base_nxt;
    logic read_ok, write_ok, read_go, write_go, room_ok;
    logic pair_valid, pair_ready, commit_valid, commit_ready;
    burst_write_pkg::beat_pair_s pair, commit;
    logic [PAIR_W-1:0] commit_bits;
    logic [LVL_W-1:0] level;

    // Selects from the positive phase only; last cycle's starter is ignored
    always_comb begin
        read_ok = !pin_r.read_port_select_n && (last_op_r != burst_write_pkg::OP_READ);
        write_ok = !pin_r.write_port_select_n && (last_op_r != burst_write_pkg::OP_WRITE);
        // Both pending: a read wins unless a read ran last cycle
        read_go = read_ok;
        // Back-pressure: with the array stalled a new burst needs an empty buffer
        room_ok = !array_hold_in || (level == '0);
        write_go = write_ok && !read_ok && room_ok;
    end

    // Data phases follow the start: pair A at t+1, pair A+2 at t+2
    always_comb begin
        phase_nxt = phase_r;
        base_nxt = base_r;
        last_op_nxt = read_go ? burst_write_pkg::OP_READ :
                      (write_go ? burst_write_pkg::OP_WRITE : burst_write_pkg::OP_NONE);
        case (phase_r)
            burst_write_pkg::WR_IDLE: begin
                phase_nxt = burst_write_pkg::WR_IDLE;
            end
            burst_write_pkg::WR_FIRST_PAIR: begin
                phase_nxt = burst_write_pkg::WR_SECOND_PAIR;
            end
            burst_write_pkg::WR_SECOND_PAIR: begin
                phase_nxt = burst_write_pkg::WR_IDLE;
            end
            default: begin
                phase_nxt = burst_write_pkg::WR_IDLE;
            end
        endcase
        if (write_go) begin
            phase_nxt = burst_write_pkg::WR_FIRST_PAIR;
            base_nxt = pin_r.addr;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_op_r <= burst_write_pkg::OP_NONE;
            phase_r <= burst_write_pkg::WR_IDLE;
            base_r <= burst_write_pkg::ADDR_RESET;
        end else begin
            last_op_r <= last_op_nxt;
            phase_r <= phase_nxt;
            base_r <= base_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture both beats of a data cycle, each with its own lane selects
    always_comb begin
        pair_valid = (phase_r != burst_write_pkg::WR_IDLE);
        pair.addr = (phase_r == burst_write_pkg::WR_SECOND_PAIR) ?
                    base_r + burst_write_pkg::PAIR_STEP : base_r;
        pair.data0 = pin_r.data_pos;
        pair.data1 = pin_r.data_neg;
        pair.en0 = ~pin_r.lane_write_select_pos_n & lane_exists;
        pair.en1 = ~pin_r.lane_write_select_neg_n & lane_exists;
    end

    pair_buffer #(
        .WIDTH(PAIR_W),
        .DEPTH(BUF_DEPTH)
    ) u_pair_buffer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(pair_valid),
        .in_ready_out(pair_ready),
        .in_data_in(PAIR_W'(pair)),
        .out_valid_out(commit_valid),
        .out_ready_in(commit_ready),
        .out_data_out(commit_bits),
        .level_out(level)
    );

    assign commit = burst_write_pkg::beat_pair_s'(commit_bits);
    assign commit_ready = !array_hold_in;

    ////////////////////////////////////////////////////////////////////////////
    // Self-timed commit: masked lanes keep their stored bits
    burst_write_pkg::word_t mem_r [DEPTH];
    burst_write_pkg::word_t mem_nxt [DEPTH];
    burst_write_pkg::addr_t addr1;

    always_comb begin
        mem_nxt = mem_r;
        addr1 = commit.addr + burst_write_pkg::BEAT_STEP;
        if (commit_valid && commit_ready) begin
            for (int l = 0; l < burst_write_pkg::MAX_LANES; l++) begin
                if (commit.en0[l]) begin
                    mem_nxt[commit.addr][l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W] =
                        commit.data0[l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W];
                end
                if (commit.en1[l]) begin
                    mem_nxt[addr1][l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W] =
                        commit.data1[l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= burst_write_pkg::WORD_RESET;
            end
        end else begin
            mem_r <= mem_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered status outputs; all low after reset, port deselected
    logic write_taken_nxt, read_taken_nxt, refused_nxt, overrun_nxt, active_nxt;
    burst_write_pkg::word_t peek_nxt;

    always_comb begin
        write_taken_nxt = write_go;
        read_taken_nxt = read_go;
        // Ignored starts: spacing violation, lost arbitration or no room
        refused_nxt = (!pin_r.write_port_select_n && !write_go) ||
                      (!pin_r.read_port_select_n && !read_go);
        // The pins cannot be stalled, so a full buffer means a lost pair
        overrun_nxt = pair_valid && !pair_ready;
        active_nxt = write_go || (phase_nxt != burst_write_pkg::WR_IDLE) || (level != '0) || pair_valid;
        peek_nxt = mem_r[peek_addr_in];
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_taken_out <= 1'b0;
            read_taken_out <= 1'b0;
            start_refused_out <= 1'b0;
            overrun_out <= 1'b0;
            port_active_out <= 1'b0;
            peek_data_out <= burst_write_pkg::WORD_RESET;
        end else begin
            write_taken_out <= write_taken_nxt;
            read_taken_out <= read_taken_nxt;
            start_refused_out <= refused_nxt;
            overrun_out <= overrun_nxt;
            port_active_out <= active_nxt;
            peek_data_out <= peek_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    write_spacing_a: assert property (write_go |=> !write_go)
        else $error("write started on consecutive cycles");
    read_spacing_a: assert property (read_go |=> !read_go)
        else $error("read started on consecutive cycles");
    one_start_a: assert property (!(read_go && write_go))
        else $error("read and write started together");
    burst_phases_a: assert property (write_go |=>
        phase_r == burst_write_pkg::WR_FIRST_PAIR ##1 phase_r == burst_write_pkg::WR_SECOND_PAIR)
        else $error("burst data phases out of order");
    pair_address_a: assert property (phase_r == burst_write_pkg::WR_FIRST_PAIR |=>
        pair.addr == $past(pair.addr) + burst_write_pkg::PAIR_STEP)
        else $error("second pair not at base plus two");
    start_flag_a: assert property (write_go |=> write_taken_out ##1 port_active_out)
        else $error("write start not reported");
    dont_care_a: assert property (write_go ##1 !pin_r.write_port_select_n && !read_ok
        |-> !write_go ##1 start_refused_out)
        else $error("select after a start not ignored");
    commit_latency_a: assert property (pair_valid && pair_ready && level == '0 && !array_hold_in
        |=> commit_valid && commit.addr == $past(pair.addr))
        else $error("captured pair not presented for commit");

    generate
        for (genvar l = 0; l < burst_write_pkg::MAX_LANES; l++) begin : g_lane_chk
            lane_written_a: assert property (commit_valid && commit_ready && commit.en0[l] && !commit.en1[l]
                |=> mem_r[$past(commit.addr)][l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W] ==
                $past(commit.data0[l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W]))
                else $error("selected lane not written");
            lane_kept_a: assert property (commit_valid && commit_ready && !commit.en0[l] && !commit.en1[l]
                |=> mem_r[$past(commit.addr)][l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W] ==
                $past(mem_r[commit.addr][l*burst_write_pkg::LANE_W +: burst_write_pkg::LANE_W]))
                else $error("deselected lane was altered");
            absent_lane_a: assert property (!lane_exists[l] |-> !pair.en0[l] && !pair.en1[l])
                else $error("lane absent in this organisation enabled");
        end
    endgenerate

    full_burst_c: cover property (write_go ##1 pair_valid ##1 pair_valid ##1 commit_valid);
    mixed_masks_c: cover property (pair_valid && pair.en0 != pair.en1);
    back_to_back_c: cover property (write_go ##1 !pin_r.write_port_select_n ##1 start_refused_out);
    both_selects_c: cover property (read_ok && !pin_r.write_port_select_n ##1 write_go);

endmodule : burst_byte_write_port

//--- ctrl_model.sv
// Purpose: Controller model that drives one write burst onto the pins.
// Assumes: Pins change on falling edges, so they are settled at each rise.
// Notes:   Released address, data and lane select lines toggle every cycle, so stale data never looks valid; the write select rests high.
`timescale 1ns/100ps
module ctrl_model (
    input wire logic clk_in, // Core clock
    input wire logic go_in, // Start a burst
    input wire logic twice_in, // Repeat the select
    input wire burst_write_pkg::addr_t a_in, // Burst address
    input wire logic [143:0] d_in, // Beats, first lowest
    input wire logic [15:0] m_in, // Lane selects per beat
    output logic wps_n_out = 1'b1, // Write port select
    output burst_write_pkg::addr_t addr_out = '1, // Address pins
    output burst_write_pkg::word_t dp_out = '1, // Positive beat
    output burst_write_pkg::word_t dn_out = '1, // Negative beat
    output burst_write_pkg::lanes_t mp_out = '1, // Selects, pos beat
    output burst_write_pkg::lanes_t mn_out = '1 // Selects, neg beat
);
    int step = 0;
    // Three-cycle sequence keeps bursts at least three cycles apart; twice_in repeats the select in the next cycle
    always @(negedge clk_in) begin
        wps_n_out <= 1'b1;
        addr_out <= ~addr_out;
        {dp_out, dn_out, mp_out, mn_out} <= ~{dp_out, dn_out, mp_out, mn_out};
        case (step)
            0: if (go_in) begin
                wps_n_out <= 1'b0;
                addr_out <= a_in;
                step <= 1;
            end
            1: begin
                wps_n_out <= ~twice_in;
                {dn_out, dp_out} <= d_in[71:0];
                {mn_out, mp_out} <= m_in[7:0];
                step <= 2;
            end
            default: begin
                {dn_out, dp_out} <= d_in[143:72];
                {mn_out, mp_out} <= m_in[15:8];
                step <= 0;
            end
        endcase
    end
endmodule : ctrl_model

//--- tb_burst_byte_write_port.sv
// Purpose: Self-checking bench, wide and narrow organisations side by side.
// Assumes: Peek port reads the array; read select is pulsed low beside the write start on some bursts.
// Notes:   Array stalls may cover a whole burst; both pairs fit the buffer, so no pair can be lost.
`timescale 1ns/100ps
module tb_burst_byte_write_port;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic go = 1'b0;
    logic tw = 1'b0;
    logic hold = 1'b0;
    logic rps_n = 1'b1;
    burst_write_pkg::addr_t a = '0;
    burst_write_pkg::addr_t peek = '0;
    logic [143:0] d = '0;
    logic [15:0] m = '1;
    logic wps_n;
    burst_write_pkg::addr_t addr;
    burst_write_pkg::word_t dp, dn, pw, pn;
    burst_write_pkg::lanes_t mp, mn;
    logic [4:0] st_w, st_n;
    burst_write_pkg::word_t mem_w [64];
    burst_write_pkg::word_t mem_n [64];
    logic [3:0] corner [6] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hf};
    int n_fail = 0;
    int tests_run = 0;
    int taken = 0;
    int refused = 0;
    int reads = 0;
    int lost = 0;
    // Clock runs free for the whole run, never stopped
    initial forever #2.5 clk_in = ~clk_in;
    ctrl_model u_ctrl_model (.clk_in(clk_in), .go_in(go), .twice_in(tw), .a_in(a), .d_in(d), .m_in(m),
        .wps_n_out(wps_n), .addr_out(addr), .dp_out(dp), .dn_out(dn), .mp_out(mp), .mn_out(mn));
    burst_byte_write_port #(.ORG_W(36)) u_burst_byte_write_port (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .write_port_select_n_in(wps_n), .read_port_select_n_in(rps_n), .addr_in(addr), .data_pos_in(dp),
        .data_neg_in(dn), .lane_write_select_pos_n_in(mp), .lane_write_select_neg_n_in(mn),
        .array_hold_in(hold), .peek_addr_in(peek), .peek_data_out(pw), .write_taken_out(st_w[4]),
        .read_taken_out(st_w[3]), .start_refused_out(st_w[2]), .overrun_out(st_w[1]), .port_active_out(st_w[0]));
    burst_byte_write_port #(.ORG_W(18)) u_burst_byte_write_port_narrow (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .write_port_select_n_in(wps_n), .read_port_select_n_in(rps_n), .addr_in(addr), .data_pos_in(dp),
        .data_neg_in(dn), .lane_write_select_pos_n_in(mp), .lane_write_select_neg_n_in(mn),
        .array_hold_in(hold), .peek_addr_in(peek), .peek_data_out(pn), .write_taken_out(st_n[4]),
        .read_taken_out(st_n[3]), .start_refused_out(st_n[2]), .overrun_out(st_n[1]), .port_active_out(st_n[0]));
    // Count status pulses once per cycle, away from the rising edge
    // Pulses last one cycle, so a check at the end of a burst alone would miss them
    always @(negedge clk_in) begin
        taken += st_w[4] + st_n[4];
        refused += st_w[2] + st_n[2];
        reads += st_w[3] + st_n[3];
        lost += st_w[1] + st_n[1];
    end
    // Lane-masked merge of one beat into the stored word
    function automatic burst_write_pkg::word_t merge(burst_write_pkg::word_t o, burst_write_pkg::word_t v,
                                                     logic [3:0] s_n, int lanes);
        merge = o;
        for (int l = 0; l < lanes; l++)
            if (!s_n[l])
                merge[l*9 +: 9] = v[l*9 +: 9];
    endfunction : merge
    task automatic cmp(string what, logic [35:0] exp, logic [35:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    // One burst; a stall may cover the whole burst since two pairs fit the buffer
    task automatic burst(int i, bit twice, bit rd);
        int t0;
        int r0;
        int q0;
        burst_write_pkg::addr_t x;
        t0 = taken;
        r0 = refused;
        q0 = reads;
        a = 6'($urandom);
        d = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
        m = 16'($urandom);
        if (i < 24)
            m = {corner[(i+3)%6], corner[(i+2)%6], corner[(i+1)%6], corner[i%6]};
        hold = 1'($urandom);
        tw = twice;
        go <= 1'b1;
        @(negedge clk_in);
        go <= 1'b0;
        // Read select low beside the write start: the read wins and no data lands
        rps_n <= !rd;
        @(negedge clk_in);
        rps_n <= 1'b1;
        repeat (7) @(negedge clk_in);
        cmp("port active", 36'({2{hold && !rd}}), 36'({st_w[0], st_n[0]}));
        hold = 1'b0;
        repeat (8) @(negedge clk_in);
        for (int k = 0; k < 4; k++) begin
            x = a + 6'(k);
            if (!rd) begin
                mem_w[x] = merge(mem_w[x], d[k*36 +: 36], m[k*4 +: 4], 4);
                mem_n[x] = merge(mem_n[x], d[k*36 +: 36], m[k*4 +: 4], 2);
            end
            peek = x;
            @(negedge clk_in);
            cmp("wide word", mem_w[x], pw);
            cmp("narrow word", mem_n[x], pn);
        end
        cmp("starts taken", (rd ? 36'h0 : 36'h2), 36'(taken - t0));
        cmp("reads taken", (rd ? 36'h2 : 36'h0), 36'(reads - q0));
        cmp("starts refused", ((twice || rd) ? 36'h2 : 36'h0), 36'(refused - r0));
        cmp("pairs lost", 36'h0, 36'(lost));
        cmp("idle status", 36'h0, 36'({st_w, st_n}));
    endtask : burst
    initial begin
        void'($urandom(32'h28d4));
        foreach (mem_w[i]) begin
            mem_w[i] = '0;
            mem_n[i] = '0;
        end
        repeat (20) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        cmp("reset status", 36'h0, 36'({st_w, st_n}));
        for (int i = 0; i < 40; i++)
            burst(i, i % 7 == 3, i % 5 == 1 && i % 7 != 3);
        summarize();
    end
    // Forty bursts take about 4 us
    initial begin
        #50000;
        n_fail++;
        summarize();
    end
endmodule : tb_burst_byte_write_port
